//--- pkg/tmoc_pkg.sv
package tmoc_pkg;
    // Register indices on the plain byte port
    localparam logic [3:0] REG_CTRL_A  = 4'h0;  // Action A[1:0], action B[3:2], force A[6], force B[7]
    localparam logic [3:0] REG_CTRL_B  = 4'h1;  // Waveform mode [3:0]
    localparam logic [3:0] REG_CNT_LO  = 4'h2;  // Counter low byte
    localparam logic [3:0] REG_CNT_HI  = 4'h3;  // Counter high byte through shared latch
    localparam logic [3:0] REG_CMPA_LO = 4'h4;  // Compare A low byte
    localparam logic [3:0] REG_CMPA_HI = 4'h5;  // Compare A high byte
    localparam logic [3:0] REG_CMPB_LO = 4'h6;  // Compare B low byte
    localparam logic [3:0] REG_CMPB_HI = 4'h7;  // Compare B high byte
    localparam logic [3:0] REG_IRQ_EN  = 4'h8;  // Enables: [0] overflow, [1] match A, [2] match B
    localparam logic [3:0] REG_FLAGS   = 4'h9;  // Flags, write one to clear, same bit layout
    localparam logic [3:0] REG_PIN_CFG = 4'hA;  // [0] direction A, [1] direction B, [2] port A, [3] port B
    localparam logic [3:0] REG_CAP_LO  = 4'hB;  // Capture value low byte (TOP source)
    localparam logic [3:0] REG_CAP_HI  = 4'hC;  // Capture value high byte

    // Field positions
    localparam int ACT_A_POS   = 0;
    localparam int ACT_B_POS   = 2;
    localparam int FORCE_A_POS = 6;
    localparam int FORCE_B_POS = 7;
    localparam int FLG_OVF_POS = 0;
    localparam int FLG_CMA_POS = 1;

    // Reset values and fixed tops
    localparam logic [15:0] CNT_RST   = 16'h0000;
    localparam logic [15:0] CMP_RST   = 16'h0000;
    localparam logic [15:0] CNT_MAX   = 16'hFFFF;
    localparam logic [15:0] FIX8_TOP  = 16'h00FF;
    localparam logic [15:0] FIX9_TOP  = 16'h01FF;
    localparam logic [15:0] FIX10_TOP = 16'h03FF;
    localparam logic        OUT_RST   = 1'b0;

    // Output action encodings
    localparam logic [1:0] ACT_NONE   = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR  = 2'h2;
    localparam logic [1:0] ACT_SET    = 2'h3;

    // Waveform modes that are not PWM; every other mode is PWM
    localparam logic [3:0] WGM_NORMAL   = 4'h0;
    localparam logic [3:0] WGM_CTC_CMP  = 4'h4;
    localparam logic [3:0] WGM_CTC_CAP  = 4'hC;

    // Per-channel pin view
    typedef struct packed {
        logic level;   // Pin value
        logic oe_n;    // Low while driving
    } tmoc_pin_s;
endpackage : tmoc_pkg

//--- rtl/tmoc_top.sv
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/100ps
module tmoc_top #(
    parameter int CH = 2                                  // Compare channels
) (
    input  wire logic                   i_mclk,           // System clock
    input  wire logic                   i_rst_n,          // Async reset, active low
    input  wire logic                   i_ce,             // Global clock enable
    input  wire logic                   i_tick,           // Timer clock enable (prescaler)
    input  wire logic [3:0]             i_addr,           // Register index
    input  wire logic [7:0]             i_wdata,          // Write data
    input  wire logic                   i_wr,             // Write strobe
    input  wire logic                   i_rd,             // Read strobe
    input  wire logic [CH-1:0]          i_irq_ack,        // Interrupt serviced, per channel
    input  wire logic                   i_ovf_ack,        // Overflow interrupt serviced
    output logic      [7:0]             o_rdata,          // Read data, cycle after strobe
    output logic      [CH-1:0]          o_cmp_irq,        // Match interrupt requests
    output logic                        o_ovf_irq,        // Overflow interrupt request
    output tmoc_pkg::tmoc_pin_s [CH-1:0] o_pin            // Compare pins
);
    // Elaboration check: the register map has room for two channels only
    if (CH != 2) begin : g_ch_check
        $error("tmoc_top serves exactly two channels");
    end

    // Control state
    logic [7:0]        ctrl_a_q;                          // Action bits
    logic [3:0]        mode_q;                            // Waveform mode
    logic [15:0]       cnt_q, cnt_d;                      // Counter value
    logic [7:0]        latch_q;                           // Shared high-byte latch
    logic [15:0]       cap_q;                             // Capture value used as top
    logic [2:0]        ien_q;                             // Interrupt enables
    logic              ovf_q;                             // Overflow flag
    logic [3:0]        pin_cfg_q;                         // Directions and port values
    logic              blk_q;                             // Counter write seen, blocks next tick
    logic [15:0]       cmp_q [CH];                        // Active compare registers
    logic [15:0]       buf_q [CH];                        // Buffer registers
    logic [CH-1:0]     match_q;                           // Registered match, flag set one tick later
    logic [CH-1:0]     flag_q;                            // Compare match flags
    logic [CH-1:0]     oc_q;                              // Compare output registers
    logic [7:0]        rdata_q;

    // Mode decode
    wire  logic        pwm_mode = !(mode_q == tmoc_pkg::WGM_NORMAL ||
                                    mode_q == tmoc_pkg::WGM_CTC_CMP ||
                                    mode_q == tmoc_pkg::WGM_CTC_CAP);
    wire  logic        dual_slope = pwm_mode && (mode_q < 4'h4 || mode_q == 4'h8 || mode_q == 4'h9
                                    || mode_q == 4'hA || mode_q == 4'hB);
    logic [15:0]       top;                               // Current counter top

    // Top selection, action bits never involved
    always_comb begin
        case (mode_q)
            4'h1, 4'h5: top = tmoc_pkg::FIX8_TOP;
            4'h2, 4'h6: top = tmoc_pkg::FIX9_TOP;
            4'h3, 4'h7: top = tmoc_pkg::FIX10_TOP;
            4'h4, 4'h9, 4'hB, 4'hF: top = cmp_q[0];
            4'h8, 4'hA, 4'hC, 4'hE: top = cap_q;
            default: top = tmoc_pkg::CNT_MAX;
        endcase
    end

    // Bus decode
    wire  logic        wr_cnt_lo = i_wr && i_addr == tmoc_pkg::REG_CNT_LO;
    wire  logic        wr_hi = i_wr && (i_addr == tmoc_pkg::REG_CNT_HI || i_addr == tmoc_pkg::REG_CMPA_HI ||
                                        i_addr == tmoc_pkg::REG_CMPB_HI || i_addr == tmoc_pkg::REG_CAP_HI);
    wire  logic        wr_ctrl_a = i_wr && i_addr == tmoc_pkg::REG_CTRL_A;
    wire  logic        wr_flags = i_wr && i_addr == tmoc_pkg::REG_FLAGS;
    wire  logic [15:0] wr_word = {latch_q, i_wdata};
    wire  logic        at_top = cnt_q == top;
    wire  logic        at_floor = cnt_q == tmoc_pkg::CNT_RST;

    // Simplified up-counter with top wrap; dual-slope shown as up-count
    logic              ovf_set;
    always_comb begin
        cnt_d = cnt_q;
        ovf_set = 1'b0;
        if (i_tick) begin
            if (at_top) begin
                cnt_d = tmoc_pkg::CNT_RST;
                ovf_set = !(mode_q == tmoc_pkg::WGM_CTC_CMP || mode_q == tmoc_pkg::WGM_CTC_CAP)
                          || cnt_q == tmoc_pkg::CNT_MAX;
            end else begin
                cnt_d = cnt_q + 16'h0001;
            end
        end
        if (wr_cnt_lo) begin
            cnt_d = wr_word;
        end
    end

    // Counter, latch, control registers
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q     <= tmoc_pkg::CNT_RST;
            latch_q   <= 8'h00;
            ctrl_a_q  <= 8'h00;
            mode_q    <= tmoc_pkg::WGM_NORMAL;
            cap_q     <= tmoc_pkg::CNT_MAX;
            ien_q     <= 3'h0;
            pin_cfg_q <= 4'h0;
            blk_q     <= 1'b0;
            ovf_q     <= 1'b0;
        end else if (i_ce) begin
            cnt_q <= cnt_d;
            if (wr_hi) latch_q <= i_wdata;
            if (wr_ctrl_a) ctrl_a_q <= {2'h0, i_wdata[5:0]};  // force bits self-clear
            if (i_wr && i_addr == tmoc_pkg::REG_CTRL_B) mode_q <= i_wdata[3:0];
            if (i_wr && i_addr == tmoc_pkg::REG_CAP_LO) cap_q <= wr_word;
            if (i_wr && i_addr == tmoc_pkg::REG_IRQ_EN) ien_q <= i_wdata[2:0];
            if (i_wr && i_addr == tmoc_pkg::REG_PIN_CFG) pin_cfg_q <= i_wdata[3:0];
            // Block holds until the next tick consumes it, even when stopped
            if (wr_cnt_lo) blk_q <= 1'b1;
            else if (i_tick) blk_q <= 1'b0;
            // Set wins over software clear and service
            if (ovf_set && !wr_cnt_lo) ovf_q <= 1'b1;
            else if ((wr_flags && i_wdata[tmoc_pkg::FLG_OVF_POS]) || i_ovf_ack) ovf_q <= 1'b0;
        end
    end

    // Per-channel compare, buffer, flag and output logic
    genvar g;
    generate
        for (g = 0; g < CH; g++) begin : g_ch
            wire logic [3:0] lo_adr = (g == 0) ? tmoc_pkg::REG_CMPA_LO : tmoc_pkg::REG_CMPB_LO;
            wire logic       wr_lo  = i_wr && i_addr == lo_adr;
            wire logic [1:0] act    = ctrl_a_q[2*g +: 2];
            // A force written together with new action bits uses the new bits
            wire logic [1:0] act_now = wr_ctrl_a ? i_wdata[2*g +: 2] : act;
            wire logic       force_s = wr_ctrl_a && i_wdata[tmoc_pkg::FORCE_A_POS + g] && !pwm_mode;
            // Comparator, gated by pending block
            wire logic       eq     = cnt_q == cmp_q[g] && !blk_q && !wr_cnt_lo;
            // Buffered load point: top for single slope, floor for dual slope
            wire logic       load   = i_tick && (dual_slope ? at_floor : at_top);
            logic            oc_d;

            // Output action on match or force
            always_comb begin
                oc_d = oc_q[g];
                if (!pwm_mode && ((i_tick && eq) || force_s)) begin
                    case (act_now)
                        tmoc_pkg::ACT_TOGGLE: oc_d = ~oc_q[g];
                        tmoc_pkg::ACT_CLEAR:  oc_d = 1'b0;
                        tmoc_pkg::ACT_SET:    oc_d = 1'b1;
                        default:              oc_d = oc_q[g];
                    endcase
                end else if (pwm_mode && i_tick && act[1]) begin
                    if (eq) oc_d = act[0] ? 1'b0 : 1'b1;       // Non-inverted sets on match
                    else if (at_top && !dual_slope) oc_d = act[0];
                end
            end

            always_ff @(posedge i_mclk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    cmp_q[g]   <= tmoc_pkg::CMP_RST;
                    buf_q[g]   <= tmoc_pkg::CMP_RST;
                    match_q[g] <= 1'b0;
                    flag_q[g]  <= 1'b0;
                    oc_q[g]    <= tmoc_pkg::OUT_RST;
                end else if (i_ce) begin
                    // CPU writes go to the buffer in PWM modes, else to compare; the buffer loads compare at the load point
                    if (wr_lo && pwm_mode) buf_q[g] <= wr_word;
                    if (wr_lo && !pwm_mode) cmp_q[g] <= wr_word;
                    else if (pwm_mode && load) cmp_q[g] <= buf_q[g];
                    if (i_tick) match_q[g] <= eq;
                    // Flag follows registered match on next tick; set wins
                    if (i_tick && match_q[g]) flag_q[g] <= 1'b1;
                    else if ((wr_flags && i_wdata[tmoc_pkg::FLG_CMA_POS + g]) || i_irq_ack[g])
                        flag_q[g] <= 1'b0;
                    oc_q[g] <= oc_d;
                end
            end

            // Pin drive and interrupt request, registered
            always_ff @(posedge i_mclk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    o_pin[g]     <= '{level: 1'b0, oe_n: 1'b1};
                    o_cmp_irq[g] <= 1'b0;
                end else if (i_ce) begin
                    o_pin[g].level <= (act != tmoc_pkg::ACT_NONE) ? oc_q[g] : pin_cfg_q[2+g];
                    o_pin[g].oe_n  <= ~pin_cfg_q[g];
                    o_cmp_irq[g]   <= flag_q[g] && ien_q[1+g];
                end
            end
        end
    endgenerate

    // Read mux; compare high reads direct (buffer when buffered)
    logic [7:0] rd_mux;
    wire  logic [15:0] cmp_view0 = pwm_mode ? buf_q[0] : cmp_q[0];
    wire  logic [15:0] cmp_view1 = pwm_mode ? buf_q[1] : cmp_q[1];
    always_comb begin
        case (i_addr)
            tmoc_pkg::REG_CTRL_A:  rd_mux = {2'h0, ctrl_a_q[5:0]};
            tmoc_pkg::REG_CTRL_B:  rd_mux = {4'h0, mode_q};
            tmoc_pkg::REG_CNT_LO:  rd_mux = cnt_q[7:0];
            tmoc_pkg::REG_CNT_HI:  rd_mux = latch_q;
            tmoc_pkg::REG_CMPA_LO: rd_mux = cmp_view0[7:0];
            tmoc_pkg::REG_CMPA_HI: rd_mux = cmp_view0[15:8];
            tmoc_pkg::REG_CMPB_LO: rd_mux = cmp_view1[7:0];
            tmoc_pkg::REG_CMPB_HI: rd_mux = cmp_view1[15:8];
            tmoc_pkg::REG_IRQ_EN:  rd_mux = {5'h00, ien_q};
            tmoc_pkg::REG_FLAGS:   rd_mux = {5'h00, flag_q, ovf_q};
            tmoc_pkg::REG_PIN_CFG: rd_mux = {4'h0, pin_cfg_q};
            tmoc_pkg::REG_CAP_LO:  rd_mux = cap_q[7:0];
            tmoc_pkg::REG_CAP_HI:  rd_mux = cap_q[15:8];
            default:               rd_mux = 8'h00;           // Unmapped reads zero
        endcase
    end

    // Read data and overflow request
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_q   <= 8'h00;
            o_ovf_irq <= 1'b0;
        end else if (i_ce) begin
            rdata_q   <= i_rd ? rd_mux : 8'h00;
            o_ovf_irq <= ovf_q && ien_q[0];
        end
    end
    assign o_rdata = rdata_q;
endmodule : tmoc_top

//--- tb/tmoc_cpu.sv
`timescale 1ns/100ps
module tmoc_cpu (
    input  wire logic       i_mclk,   // System clock
    input  wire logic [7:0] i_rdata,  // Read data from the block
    output logic      [3:0] o_addr,   // Register index
    output logic      [7:0] o_wdata,  // Write data
    output logic            o_wr,     // Write strobe
    output logic            o_rd      // Read strobe
);
    // Idle bus at time zero
    initial begin
        o_addr = 4'h0;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    // One-cycle write; data inverted after so a stale byte never looks valid
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_mclk);
        o_wr <= 1'b0;
        o_wdata <= ~d;
    endtask : wr
    // High byte into the shared latch first, low byte commits both
    task automatic wr16(input logic [3:0] a_hi, input logic [15:0] v);
        wr(a_hi, v[15:8]);
        wr(a_hi - 4'h1, v[7:0]);
    endtask : wr16
    // Data is taken mid-cycle after the strobe, clear of edge races
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_mclk);
        o_rd <= 1'b0;
        @(negedge i_mclk);
        d = i_rdata;
    endtask : rd
endmodule : tmoc_cpu

//--- tb/tmoc_top_chk.sv
`timescale 1ns/100ps
module tmoc_top_chk #(
    parameter int CH = 2                                   // Compare channels
) (
    input wire logic                     i_mclk,
    input wire logic                     i_rst_n,
    input wire logic                     i_ce,
    input wire logic                     i_tick,
    input wire logic [3:0]               i_addr,
    input wire logic [7:0]               i_wdata,
    input wire logic                     i_wr,
    input wire logic                     i_rd,
    input wire logic [CH-1:0]            i_irq_ack,
    input wire logic                     i_ovf_ack,
    input wire logic [7:0]               o_rdata,
    input wire logic [CH-1:0]            o_cmp_irq,
    input wire logic                     o_ovf_irq,
    input wire tmoc_pkg::tmoc_pin_s [CH-1:0] o_pin
);
    // Write to the flag register
    wire logic fl_wr = i_wr && i_addr == tmoc_pkg::REG_FLAGS;
    // Write to the pin setup register
    wire logic cfg_wr = i_wr && i_addr == tmoc_pkg::REG_PIN_CFG;
    // No tick, no write and no service pulse; reads allowed
    wire logic quiet = !i_tick && !i_wr && !(|i_irq_ack) && !i_ovf_ack;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("read data outside its slot");
    a_oe_cause: assert property ($changed(o_pin[0].oe_n) |-> $past(cfg_wr) || $past(cfg_wr, 2))
        else $error("pin enable moved without setup write");
    a_irq_cause: assert property ($rose(o_cmp_irq[0]) |-> $past(i_tick, 2) || $past(i_wr, 2))
        else $error("match request without tick");
    a_ack_clears: assert property (i_irq_ack[0] && !i_tick ##1 !i_tick |=> !o_cmp_irq[0])
        else $error("service did not clear match request");
    a_w1c_clears: assert property (fl_wr && i_wdata[0] && !i_tick ##1 !i_tick |=> !o_ovf_irq)
        else $error("write one did not clear overflow");
    a_w0_keeps: assert property (fl_wr && i_wdata == 8'h00 && o_cmp_irq[0] && !i_irq_ack[0] && !i_tick
        ##1 !i_tick |=> o_cmp_irq[0]) else $error("write zero cleared a flag");
    a_stop_holds: assert property (quiet [*3] |-> $stable(o_cmp_irq) && $stable(o_ovf_irq) && $stable(o_pin))
        else $error("state moved while timer stopped");
    a_level_cause: assert property ($changed(o_pin[0].level) |-> $past(i_wr) || $past(i_wr, 2)
        || $past(i_tick) || $past(i_tick, 2)) else $error("pin level moved without cause");

    // Main scenarios reached
    c_match: cover property ($rose(o_cmp_irq[0]));
    c_ovf: cover property ($rose(o_ovf_irq));
    c_pin_fall: cover property ($fell(o_pin[0].level));
endmodule : tmoc_top_chk

//--- tb/tmoc_top_tb.sv
`timescale 1ns/100ps
module tmoc_top_tb;
    logic                      i_mclk;      // System clock
    logic                      i_rst_n;     // Reset, active low
    logic                      i_tick;      // Timer clock enable
    logic [1:0]                i_irq_ack;   // Match service pulses
    logic [3:0]                i_addr;      // Index from the model
    logic [7:0]                i_wdata;     // Write data from the model
    logic                      i_wr;        // Write strobe
    logic                      i_rd;        // Read strobe
    logic [7:0]                o_rdata;     // Read data
    logic [1:0]                o_cmp_irq;   // Match requests
    logic                      o_ovf_irq;   // Overflow request
    tmoc_pkg::tmoc_pin_s [1:0] o_pin;       // Compare pins
    logic [7:0]                rv;          // Last read byte
    int                        miscompares = 0;
    int                        comparisons = 0;
    // Action and force steps; pin level alternates 1,0,1,0,1,0
    localparam logic [7:0] CTL[6] = '{8'h43, 8'h40, 8'h01, 8'h42, 8'h41, 8'h41};

    tmoc_top #(.CH(2)) i_tmoc_top (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_tick(i_tick),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_irq_ack(i_irq_ack), .i_ovf_ack(1'b0),
        .o_rdata(o_rdata), .o_cmp_irq(o_cmp_irq), .o_ovf_irq(o_ovf_irq), .o_pin(o_pin));
    tmoc_cpu i_tmoc_cpu (.i_mclk(i_mclk), .i_rdata(o_rdata), .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr),
        .o_rd(i_rd));

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge i_mclk);
    endtask : step
    task automatic rdc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp, input string nm);
        i_tmoc_cpu.rd(a, rv);
        chk(nm, exp, rv & m);
    endtask : rdc
    // Run the timer until a request shows, bounded so a dead comparator cannot hang
    task automatic run_until(input bit ovf);
        int k;
        @(posedge i_mclk);
        i_tick <= 1'b1;
        for (k = 0; k < 40 && (ovf ? o_ovf_irq : o_cmp_irq[0]) !== 1'b1; k++) @(posedge i_mclk);
        i_tick <= 1'b0;
        if (k == 40) chk("irq wait", 8'h01, 8'h00);
        step(3);
    endtask : run_until
    task automatic complete_run();
        if (miscompares == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    initial begin
        i_mclk = 1'b0;
        forever #4 i_mclk = ~i_mclk;
    end
    // Watchdog far beyond the fewer than 200 cycles the run needs
    initial begin
        #(3000 * 8);
        miscompares++;
        complete_run();
    end
    initial begin
        i_rst_n = 1'b0;
        i_tick = 1'b0;
        i_irq_ack = 2'h0;
        step(4);
        i_rst_n <= 1'b1;
        // Byte access through the shared latch
        i_tmoc_cpu.wr16(tmoc_pkg::REG_CMPA_HI, 16'h1234);
        rdc(tmoc_pkg::REG_CMPA_LO, 8'hFF, 8'h34, "cmpa low");
        rdc(tmoc_pkg::REG_CMPA_HI, 8'hFF, 8'h12, "cmpa high");
        i_tmoc_cpu.wr(tmoc_pkg::REG_CMPB_HI, 8'h56);
        i_tmoc_cpu.wr(tmoc_pkg::REG_CMPA_LO, 8'h78);
        rdc(tmoc_pkg::REG_CMPA_HI, 8'hFF, 8'h56, "cmpa high via latch");
        rdc(tmoc_pkg::REG_CMPB_HI, 8'hFF, 8'h00, "cmpb high untouched");
        rdc(4'hF, 8'hFF, 8'h00, "unmapped");
        // Forced actions on pin A, port bit low so override is visible
        i_tmoc_cpu.wr(tmoc_pkg::REG_PIN_CFG, 8'h01);
        for (int k = 0; k < 6; k++) begin
            i_tmoc_cpu.wr(tmoc_pkg::REG_CTRL_A, CTL[k]);
            step(3);
            chk("pin a level", {7'h00, k % 2 == 0}, {7'h00, o_pin[0].level});
        end
        chk("pin a enable", 8'h00, {7'h00, o_pin[0].oe_n});
        chk("pin b enable", 8'h01, {7'h00, o_pin[1].oe_n});
        // Mode changes keep the output; force refused in a PWM mode
        i_tmoc_cpu.wr(tmoc_pkg::REG_CTRL_A, 8'h43);
        i_tmoc_cpu.wr(tmoc_pkg::REG_CTRL_B, 8'h04);
        i_tmoc_cpu.wr(tmoc_pkg::REG_CTRL_B, 8'h0E);
        i_tmoc_cpu.wr(tmoc_pkg::REG_CTRL_A, 8'h42);
        i_tmoc_cpu.wr(tmoc_pkg::REG_CTRL_B, 8'h00);
        step(3);
        chk("pin a kept", 8'h01, {7'h00, o_pin[0].level});
        // Real match with toggle action
        i_tmoc_cpu.wr16(tmoc_pkg::REG_CMPA_HI, 16'h0014);
        i_tmoc_cpu.wr16(tmoc_pkg::REG_CNT_HI, 16'h0010);
        i_tmoc_cpu.wr(tmoc_pkg::REG_IRQ_EN, 8'h03);
        i_tmoc_cpu.wr(tmoc_pkg::REG_CTRL_A, 8'h01);
        run_until(1'b0);
        chk("pin a toggled", 8'h00, {7'h00, o_pin[0].level});
        rdc(tmoc_pkg::REG_FLAGS, 8'hFF, 8'h02, "flags match");
        i_tmoc_cpu.wr(tmoc_pkg::REG_FLAGS, 8'h00);
        step(3);
        chk("irq after zero write", 8'h01, {7'h00, o_cmp_irq[0]});
        @(posedge i_mclk);
        i_irq_ack <= 2'h1;
        @(posedge i_mclk);
        i_irq_ack <= 2'h0;
        step(3);
        chk("irq after service", 8'h00, {7'h00, o_cmp_irq[0]});
        // Counter written equal to compare: that match is blocked
        i_tmoc_cpu.wr16(tmoc_pkg::REG_CNT_HI, 16'h0014);
        @(posedge i_mclk);
        i_tick <= 1'b1;
        step(6);
        i_tick <= 1'b0;
        step(3);
        rdc(tmoc_pkg::REG_FLAGS, 8'h02, 8'h00, "flags blocked");
        rdc(tmoc_pkg::REG_CNT_LO, 8'hFF, 8'h1A, "counter low");
        // Wrap past the top
        i_tmoc_cpu.wr16(tmoc_pkg::REG_CNT_HI, 16'hFFFE);
        run_until(1'b1);
        rdc(tmoc_pkg::REG_FLAGS, 8'h01, 8'h01, "flags overflow");
        i_tmoc_cpu.wr(tmoc_pkg::REG_FLAGS, 8'h01);
        step(3);
        chk("overflow irq", 8'h00, {7'h00, o_ovf_irq});
        complete_run();
    end
endmodule : tmoc_top_tb

bind tmoc_top tmoc_top_chk #(.CH(CH)) i_tmoc_top_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce),
    .i_tick(i_tick), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_irq_ack(i_irq_ack),
    .i_ovf_ack(i_ovf_ack), .o_rdata(o_rdata), .o_cmp_irq(o_cmp_irq), .o_ovf_irq(o_ovf_irq), .o_pin(o_pin));
